// ===== lioreg_bank.sv
// Purpose: Low I/O register bank, addresses 0x00 to 0x17, on the core I/O bus.
// Assumes: One request per cycle; read data and test answer follow one cycle later.
// Notes:   Set, clear and test act on single bits in the low thirty-two addresses.
`timescale 1ns/1ns
`default_nettype none
`include "lioreg_map.svh"

module lioreg_bank (
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    input  wire lioreg_pkg::lioreg_req_s    req,
    input  wire lioreg_pkg::lioreg_periph_s periph,
    output logic [7:0]                      rdata_q,
    output logic                            rvalid_q,
    output logic                            test_bit_q,
    output logic                            skip_if_io_bit_one_instr_q,
    output logic                            skip_if_io_bit_zero_instr_q,
    output logic [7:0]                      power_reduction_q,
    output logic [7:0]                      digital_input_disable_q,
    output logic [7:0]                      converter_control_b_q,
    output logic [7:0]                      converter_control_a_q,
    output logic [7:0]                      converter_input_select_q,
    output logic [7:0]                      comparator_control_q,
    output logic [7:0]                      timer1_mask_q,
    output logic [7:0]                      serial_control_q,
    output logic [7:0]                      serial_data_q,
    output logic                            serial_data_wr_q,
    output logic [3:0]                      serial_count_wr_q,
    output logic                            serial_count_we_q,
    output logic [7:0]                      pin_change_mask_q,
    output logic [7:0]                      port_b_dir_q,
    output logic [3:0]                      port_b_toggle_q
);
    // ======================================================================
    // Current value and request decode
    // ======================================================================
    logic [7:0] cur;
    logic [7:0] wmask;
    logic [7:0] wval;
    logic       bit_ok;
    logic [7:0] scratch_q [3];
    logic [7:0] cnv_flag_q;
    logic [7:0] t1_flag_q;
    logic [7:0] ser_flag_q;
    logic [7:0] cmp_flag_q;
    logic [7:0] cmp_view;
    logic [7:0] cnva_view;
    logic [7:0] sers_view;
    logic       wr_hit;

    assign cmp_view  = (comparator_control_q & `LIO_M_CMP) | cmp_flag_q
                     | ({7'h00, periph.cmp_out} << `LIO_B_CMP_OUT);
    assign cnva_view = (converter_control_a_q & `LIO_M_CNVA) | cnv_flag_q;
    assign sers_view = ser_flag_q | {4'h0, periph.ser_count};

    always_comb begin
        unique case (req.addr)
            `LIO_A_PWR:    cur = power_reduction_q;
            `LIO_A_DIDIS:  cur = digital_input_disable_q;
            `LIO_A_CNVB:   cur = converter_control_b_q;
            `LIO_A_RESL:   cur = periph.res_low;
            `LIO_A_RESH:   cur = periph.res_high;
            `LIO_A_CNVA:   cur = cnva_view;
            `LIO_A_INSEL:  cur = converter_input_select_q;
            `LIO_A_CMP:    cur = cmp_view;
            `LIO_A_T1FLG:  cur = t1_flag_q;
            `LIO_A_T1MSK:  cur = timer1_mask_q;
            `LIO_A_SERCTL: cur = serial_control_q;
            `LIO_A_SERSTS: cur = sers_view;
            `LIO_A_SERDAT: cur = serial_data_q;
            `LIO_A_SERBUF: cur = periph.ser_buf;
            `LIO_A_PCMSK:  cur = pin_change_mask_q;
            `LIO_A_SCR0:   cur = scratch_q[0];
            `LIO_A_SCR1:   cur = scratch_q[1];
            `LIO_A_SCR2:   cur = scratch_q[2];
            `LIO_A_PBIN:   cur = {4'h0, periph.pins};
            `LIO_A_PBDIR:  cur = port_b_dir_q;
            default:       cur = `LIO_RST_VAL;
        endcase
    end

    lioreg_decode u_decode (
        .req    (req),
        .cur    (cur),
        .wmask  (wmask),
        .wval   (wval),
        .bit_ok (bit_ok)
    );

    assign wr_hit = |wmask;

    // ======================================================================
    // Read and bit test answers
    // ======================================================================
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q    <= `LIO_RST_VAL;
            rvalid_q   <= 1'b0;
            test_bit_q <= 1'b0;
            skip_if_io_bit_one_instr_q  <= 1'b0;
            skip_if_io_bit_zero_instr_q <= 1'b0;
        end else begin
            rdata_q    <= cur;
            rvalid_q   <= req.valid && (req.op == lioreg_pkg::LIOREG_OP_WRITE) ? 1'b0 : req.valid;
            test_bit_q <= cur[req.bit_sel];
            skip_if_io_bit_one_instr_q  <= req.valid && req.op == lioreg_pkg::LIOREG_OP_TEST
                                        && bit_ok && cur[req.bit_sel];
            skip_if_io_bit_zero_instr_q <= req.valid && req.op == lioreg_pkg::LIOREG_OP_TEST
                                        && bit_ok && !cur[req.bit_sel];
        end
    end

    // ======================================================================
    // Plain control registers
    // ======================================================================
    function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] m);
        upd = (old & ~(wmask & m)) | (wval & wmask & m);
    endfunction

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            power_reduction_q        <= `LIO_RST_VAL;
            digital_input_disable_q  <= `LIO_RST_VAL;
            converter_control_b_q    <= `LIO_RST_VAL;
            converter_control_a_q    <= `LIO_RST_VAL;
            converter_input_select_q <= `LIO_RST_VAL;
            comparator_control_q     <= `LIO_RST_VAL;
            timer1_mask_q            <= `LIO_RST_VAL;
            serial_control_q         <= `LIO_RST_VAL;
            pin_change_mask_q        <= `LIO_RST_VAL;
            port_b_dir_q             <= `LIO_RST_VAL;
        end else if (wr_hit) begin
            unique case (req.addr)
                `LIO_A_PWR:    power_reduction_q <= upd(power_reduction_q, `LIO_M_PWR);
                `LIO_A_DIDIS:  digital_input_disable_q <= upd(digital_input_disable_q, 8'hFF);
                `LIO_A_CNVB:   converter_control_b_q <= upd(converter_control_b_q, `LIO_M_CNVB);
                `LIO_A_CNVA:   converter_control_a_q <= upd(converter_control_a_q, `LIO_M_CNVA);
                `LIO_A_INSEL:  converter_input_select_q <= upd(converter_input_select_q, 8'hFF);
                `LIO_A_CMP:    comparator_control_q <= upd(comparator_control_q, `LIO_M_CMP);
                `LIO_A_T1MSK:  timer1_mask_q <= upd(timer1_mask_q, `LIO_M_T1MSK);
                `LIO_A_SERCTL: serial_control_q <= upd(serial_control_q, 8'hFF);
                `LIO_A_PCMSK:  pin_change_mask_q <= upd(pin_change_mask_q, 8'hFF);
                `LIO_A_PBDIR:  port_b_dir_q <= upd(port_b_dir_q, `LIO_M_PORTB);
                default: begin
                end
            endcase
        end
    end

    // ======================================================================
    // General scratch registers
    // ======================================================================
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_scr
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    scratch_q[gi] <= `LIO_RST_VAL;
                end else if (wr_hit && req.addr == `LIO_A_SCR0 + 6'(gi)) begin
                    scratch_q[gi] <= upd(scratch_q[gi], 8'hFF);
                end
            end
        end
    endgenerate

    // ======================================================================
    // Serial data, counter load and pin toggle strobes
    // ======================================================================
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serial_data_q     <= `LIO_RST_VAL;
            serial_data_wr_q  <= 1'b0;
            serial_count_wr_q <= 4'h0;
            serial_count_we_q <= 1'b0;
            port_b_toggle_q   <= 4'h0;
        end else begin
            serial_data_wr_q  <= wr_hit && req.addr == `LIO_A_SERDAT;
            serial_count_we_q <= wr_hit && req.addr == `LIO_A_SERSTS
                              && |(wmask & `LIO_M_SERSTS);
            serial_count_wr_q <= wval[3:0];
            port_b_toggle_q   <= (wr_hit && req.addr == `LIO_A_PBIN)
                              ? (wmask[3:0] & wval[3:0] & ~periph.pins) : 4'h0;
            if (wr_hit && req.addr == `LIO_A_SERDAT) begin
                serial_data_q <= upd(serial_data_q, 8'hFF);
            end
        end
    end

    // ======================================================================
    // Write-one-to-clear flags
    // ======================================================================
    lioreg_flag u_t1 (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .flag_mask (`LIO_F_T1FLG),
        .events    (periph.t1_flags),
        .wmask     ((req.addr == `LIO_A_T1FLG) ? wmask : 8'h00),
        .wval      (wval),
        .flags_q   (t1_flag_q)
    );

    lioreg_flag u_ser (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .flag_mask (`LIO_F_SERSTS),
        .events    (periph.ser_flags),
        .wmask     ((req.addr == `LIO_A_SERSTS) ? wmask : 8'h00),
        .wval      (wval),
        .flags_q   (ser_flag_q)
    );

    lioreg_flag u_cnv (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .flag_mask (`LIO_F_CNVA),
        .events    (periph.cnv_flags),
        .wmask     ((req.addr == `LIO_A_CNVA) ? wmask : 8'h00),
        .wval      (wval),
        .flags_q   (cnv_flag_q)
    );

    lioreg_flag u_cmp (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .flag_mask (`LIO_F_CMP),
        .events    ({3'h0, periph.cmp_event, 4'h0}),
        .wmask     ((req.addr == `LIO_A_CMP) ? wmask : 8'h00),
        .wval      (wval),
        .flags_q   (cmp_flag_q)
    );

    // Reserved bits read zero; reserved addresses read zero and store nothing.
endmodule

`default_nettype wire

// ===== lioreg_core_model.sv
// Purpose: Processor core model issuing I/O and bit requests.
// Assumes: One request at a time, answer one edge after it is taken.
// Notes:   Idle address and bit fields show the inverse of the last request, data the inverse of the unmasked write data; op is kept.
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Core model
// ==========================================================================
module lioreg_core_model (
    input wire logic                     core_clk,
    output var lioreg_pkg::lioreg_req_s  req,
    input wire logic [7:0]               rdata_q,
    input wire logic                     skip_one,
    input wire logic                     skip_zero
);
    initial req = '0;

    task automatic access(input lioreg_pkg::lioreg_op_e op, input logic [5:0] a,
                          input logic [2:0] b, input logic [7:0] wd,
                          output logic [7:0] rd, output logic [1:0] sk);
        logic [7:0] m;
        case (a)
            6'h00, 6'h16, 6'h17: m = 8'h0F;
            6'h03: m = 8'hD7;
            6'h0B, 6'h0C: m = 8'h27;
            default: m = 8'hFF;
        endcase
        rd = 8'h00;
        sk = 2'b00;
        if (op == lioreg_pkg::LIOREG_OP_WRITE && (a == 6'h02 || a == 6'h09 || a == 6'h0A
            || a == 6'h11)) begin
            return;
        end
        @(posedge core_clk);
        req <= '{valid: 1'b1, op: op, addr: a, bit_sel: b, wdata: wd & m};
        @(posedge core_clk);
        req <= '{valid: 1'b0, op: op, addr: ~a, bit_sel: ~b, wdata: ~wd};
        #1;
        rd = rdata_q;
        sk = {skip_one, skip_zero};
    endtask
endmodule
`default_nettype wire

// ===== lioreg_decode.sv
// Purpose: Turns one core request into a per-bit write mask and write value.
// Assumes: Requests are already qualified by the caller.
// Notes:   Bit operations are limited to the low thirty-two addresses.
`timescale 1ns/1ns
`default_nettype none
`include "lioreg_map.svh"

module lioreg_decode (
    input  wire lioreg_pkg::lioreg_req_s req,
    input  wire logic [7:0]              cur,
    output logic [7:0]                   wmask,
    output logic [7:0]                   wval,
    output logic                         bit_ok
);
    logic [7:0] sel;

    assign sel    = 8'h01 << req.bit_sel;
    assign bit_ok = (req.addr <= `LIO_A_BITTOP);

    always_comb begin
        wmask = 8'h00;
        wval  = cur;
        if (req.valid) begin
            unique case (req.op)
                lioreg_pkg::LIOREG_OP_WRITE: begin
                    wmask = 8'hFF;
                    wval  = req.wdata;
                end
                lioreg_pkg::LIOREG_OP_SET: begin
                    if (bit_ok) begin
                        wmask = sel;
                        wval  = cur | sel;
                    end
                end
                lioreg_pkg::LIOREG_OP_CLEAR: begin
                    if (bit_ok) begin
                        wmask = sel;
                        wval  = cur & ~sel;
                    end
                end
                lioreg_pkg::LIOREG_OP_TEST: begin
                    wmask = 8'h00;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// ===== lioreg_flag.sv
// Purpose: One byte of sticky status flags that clear on a written one.
// Assumes: Event inputs are one-cycle pulses.
// Notes:   A new event wins over a clear in the same cycle.
`timescale 1ns/1ns
`default_nettype none
`include "lioreg_map.svh"

module lioreg_flag (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic [7:0] flag_mask,
    input  wire logic [7:0] events,
    input  wire logic [7:0] wmask,
    input  wire logic [7:0] wval,
    output logic [7:0]      flags_q
);
    logic [7:0] clr;

    assign clr = wmask & wval & flag_mask;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flags_q <= `LIO_RST_VAL;
        end else begin
            flags_q <= ((flags_q & ~clr) | events) & flag_mask;
        end
    end
endmodule

`default_nettype wire

// ===== lioreg_map.svh
// Purpose: Addresses, field positions and reset values of the low I/O register bank.
// Assumes: Byte-wide I/O bus driven by the processor core.
// Notes:   Definitions only.
`ifndef LIOREG_MAP_SVH
`define LIOREG_MAP_SVH

// ==========================================================================
// Addresses
// ==========================================================================
`define LIO_A_PWR      6'h00
`define LIO_A_DIDIS    6'h01
`define LIO_A_RSV2     6'h02
`define LIO_A_CNVB     6'h03
`define LIO_A_RESL     6'h04
`define LIO_A_RESH     6'h05
`define LIO_A_CNVA     6'h06
`define LIO_A_INSEL    6'h07
`define LIO_A_CMP      6'h08
`define LIO_A_RSV9     6'h09
`define LIO_A_RSVA     6'h0A
`define LIO_A_T1FLG    6'h0B
`define LIO_A_T1MSK    6'h0C
`define LIO_A_SERCTL   6'h0D
`define LIO_A_SERSTS   6'h0E
`define LIO_A_SERDAT   6'h0F
`define LIO_A_SERBUF   6'h10
`define LIO_A_RSV11    6'h11
`define LIO_A_PCMSK    6'h12
`define LIO_A_SCR0     6'h13
`define LIO_A_SCR1     6'h14
`define LIO_A_SCR2     6'h15
`define LIO_A_PBIN     6'h16
`define LIO_A_PBDIR    6'h17
`define LIO_A_BITTOP   6'h1F

// ==========================================================================
// Writable masks, flag masks, bit positions and reset values
// ==========================================================================
`define LIO_M_PWR      8'h0F
`define LIO_M_CNVB     8'hD7
`define LIO_M_CNVA     8'hEF
`define LIO_F_CNVA     8'h10
`define LIO_M_CMP      8'hCF
`define LIO_F_CMP      8'h10
`define LIO_F_T1FLG    8'h27
`define LIO_M_T1MSK    8'h27
`define LIO_F_SERSTS   8'hE0
`define LIO_M_SERSTS   8'h0F
`define LIO_M_PORTB    8'h0F
`define LIO_RST_VAL    8'h00
`define LIO_B_CMP_OUT  5
`define LIO_B_CMP_FLAG 4
`define LIO_B_CNV_FLAG 4

`endif

// ===== lioreg_pkg.sv
// Purpose: Types shared by the low I/O register bank.
// Assumes: Numbers are written out here; no map header is included.
// Notes:   Types only.
package lioreg_pkg;

    typedef logic [7:0] lioreg_byte_t;
    typedef logic [5:0] lioreg_addr_t;

    typedef enum logic [1:0] {
        LIOREG_OP_WRITE = 2'b00,
        LIOREG_OP_SET   = 2'b01,
        LIOREG_OP_CLEAR = 2'b10,
        LIOREG_OP_TEST  = 2'b11
    } lioreg_op_e;

    typedef struct packed {
        logic         valid;
        lioreg_op_e   op;
        lioreg_addr_t addr;
        logic [2:0]   bit_sel;
        lioreg_byte_t wdata;
    } lioreg_req_s;

    typedef struct packed {
        lioreg_byte_t cnv_flags;
        lioreg_byte_t t1_flags;
        lioreg_byte_t ser_flags;
        logic         cmp_out;
        logic         cmp_event;
        logic [7:0]   res_low;
        logic [7:0]   res_high;
        logic [7:0]   ser_buf;
        logic [3:0]   ser_count;
        logic [3:0]   pins;
    } lioreg_periph_s;

endpackage

// ===== lioreg_props.sv
// Purpose: Checker for the ports of the low I/O register bank.
// Assumes: Bound to lioreg_bank, one clock domain.
// Notes:   Watches bit tests, read strobes and control register updates.
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Checker
// ==========================================================================
module lioreg_props (
    input wire logic                    core_clk,
    input wire logic                    nrst,
    input wire lioreg_pkg::lioreg_req_s req,
    input wire logic                    rvalid_q,
    input wire logic                    test_bit_q,
    input wire logic                    skip_if_io_bit_one_instr_q,
    input wire logic                    skip_if_io_bit_zero_instr_q,
    input wire logic [7:0]              power_reduction_q,
    input wire logic [7:0]              serial_data_q,
    input wire logic                    serial_data_wr_q,
    input wire logic [7:0]              port_b_dir_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_low_test;
        req.valid && req.op == lioreg_pkg::LIOREG_OP_TEST && req.addr <= 6'h1F;
    endsequence
    sequence s_skip_given;
        (skip_if_io_bit_one_instr_q ^ skip_if_io_bit_zero_instr_q)
            && (skip_if_io_bit_one_instr_q == test_bit_q);
    endsequence

    property p_test_answer;
        s_low_test |=> s_skip_given;
    endproperty
    property p_skip_cause;
        (skip_if_io_bit_one_instr_q || skip_if_io_bit_zero_instr_q) |->
            $past(req.valid && req.op == lioreg_pkg::LIOREG_OP_TEST && req.addr <= 6'h1F);
    endproperty
    property p_no_skip_high;
        req.valid && req.op == lioreg_pkg::LIOREG_OP_TEST && req.addr > 6'h1F |=>
            !skip_if_io_bit_one_instr_q && !skip_if_io_bit_zero_instr_q;
    endproperty
    property p_rvalid;
        req.valid && req.op != lioreg_pkg::LIOREG_OP_WRITE |=> rvalid_q;
    endproperty
    property p_pwr_set;
        req.valid && req.op == lioreg_pkg::LIOREG_OP_SET && req.addr == 6'h00 && req.bit_sel < 4
            |=> power_reduction_q == ($past(power_reduction_q) | (8'h01 << $past(req.bit_sel)));
    endproperty
    property p_dir_clear;
        req.valid && req.op == lioreg_pkg::LIOREG_OP_CLEAR && req.addr == 6'h17
            |=> port_b_dir_q == ($past(port_b_dir_q) & ~(8'h01 << $past(req.bit_sel)));
    endproperty
    property p_dir_write;
        req.valid && req.op == lioreg_pkg::LIOREG_OP_WRITE && req.addr == 6'h17
            |=> port_b_dir_q == ($past(req.wdata) & 8'h0F);
    endproperty
    property p_dir_hold;
        !(req.valid && req.addr == 6'h17 && req.op != lioreg_pkg::LIOREG_OP_TEST)
            |=> $stable(port_b_dir_q);
    endproperty
    property p_ser_write;
        req.valid && req.op == lioreg_pkg::LIOREG_OP_WRITE && req.addr == 6'h0F
            |=> serial_data_wr_q && serial_data_q == $past(req.wdata);
    endproperty

    a_test_answer: assert property (p_test_answer) else $error("bit test answer wrong");
    a_skip_cause: assert property (p_skip_cause) else $error("skip without low test");
    a_no_skip_high: assert property (p_no_skip_high) else $error("skip above 0x1F");
    a_rvalid: assert property (p_rvalid) else $error("read strobe missing");
    a_pwr_set: assert property (p_pwr_set) else $error("bit set wrong");
    a_dir_clear: assert property (p_dir_clear) else $error("bit clear wrong");
    a_dir_write: assert property (p_dir_write) else $error("byte write wrong");
    a_dir_hold: assert property (p_dir_hold) else $error("direction changed alone");
    a_ser_write: assert property (p_ser_write) else $error("data write wrong");
endmodule

bind lioreg_bank lioreg_props u_props (
    .core_clk                    (core_clk),
    .nrst                        (nrst),
    .req                         (req),
    .rvalid_q                    (rvalid_q),
    .test_bit_q                  (test_bit_q),
    .skip_if_io_bit_one_instr_q  (skip_if_io_bit_one_instr_q),
    .skip_if_io_bit_zero_instr_q (skip_if_io_bit_zero_instr_q),
    .power_reduction_q           (power_reduction_q),
    .serial_data_q               (serial_data_q),
    .serial_data_wr_q            (serial_data_wr_q),
    .port_b_dir_q                (port_b_dir_q)
);
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench of the low I/O register bank.
// Assumes: Core model drives the request port.
// Notes:   Table of byte accesses first, then bit operations, flags and reset.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); err_total++; end end

module testbench;
    typedef struct packed {
        logic [5:0] a;
        logic       wr;
        logic [7:0] wd;
        logic [7:0] ex;
    } lioreg_row_s;

    logic                       core_clk = 1'b0;
    logic                       nrst = 1'b0;
    lioreg_pkg::lioreg_req_s    req;
    lioreg_pkg::lioreg_periph_s periph = '0;
    logic [7:0]                 rdata_q;
    logic                       rvalid_q;
    logic                       test_bit_q;
    logic                       sk1;
    logic                       sk0;
    logic [7:0]                 pwr;
    logic [7:0]                 dir;
    logic [3:0]                 tog;
    logic [7:0]                 rd;
    logic [1:0]                 sk;
    int                         err_total = 0;
    int                         samples_checked = 0;
    int                         cycles = 0;
    lioreg_row_s rows [0:17] = '{
        '{6'h00, 1'b1, 8'hFF, 8'h0F}, '{6'h01, 1'b1, 8'hA5, 8'hA5}, '{6'h02, 1'b0, 8'h00, 8'h00},
        '{6'h03, 1'b1, 8'hFF, 8'hD7}, '{6'h04, 1'b1, 8'hFF, 8'h3C}, '{6'h05, 1'b0, 8'h00, 8'h81},
        '{6'h06, 1'b1, 8'hFF, 8'hEF}, '{6'h07, 1'b1, 8'h5A, 8'h5A}, '{6'h08, 1'b1, 8'hFF, 8'hCF},
        '{6'h0C, 1'b1, 8'hFF, 8'h27}, '{6'h0D, 1'b1, 8'h3C, 8'h3C}, '{6'h0F, 1'b1, 8'h96, 8'h96},
        '{6'h10, 1'b0, 8'h00, 8'hC3}, '{6'h12, 1'b1, 8'hFF, 8'hFF}, '{6'h13, 1'b1, 8'h11, 8'h11},
        '{6'h14, 1'b1, 8'h22, 8'h22}, '{6'h15, 1'b1, 8'h44, 8'h44}, '{6'h17, 1'b1, 8'hFF, 8'h0F}};

    always #4 core_clk = ~core_clk;

    lioreg_bank dut (.core_clk(core_clk), .nrst(nrst), .req(req), .periph(periph),
        .rdata_q(rdata_q), .rvalid_q(rvalid_q), .test_bit_q(test_bit_q),
        .skip_if_io_bit_one_instr_q(sk1), .skip_if_io_bit_zero_instr_q(sk0),
        .power_reduction_q(pwr), .digital_input_disable_q(), .converter_control_b_q(),
        .converter_control_a_q(), .converter_input_select_q(), .comparator_control_q(),
        .timer1_mask_q(), .serial_control_q(), .serial_data_q(), .serial_data_wr_q(),
        .serial_count_wr_q(), .serial_count_we_q(), .pin_change_mask_q(),
        .port_b_dir_q(dir), .port_b_toggle_q(tog));

    lioreg_core_model core (.core_clk(core_clk), .req(req), .rdata_q(rdata_q),
        .skip_one(sk1), .skip_zero(sk0));

    // ======================================================================
    // Helpers
    // ======================================================================
    task automatic op(input lioreg_pkg::lioreg_op_e o, input logic [5:0] a,
                      input logic [2:0] b, input logic [7:0] wd);
        core.access(o, a, b, wd, rd, sk);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            final_report();
        end
    end

    // ======================================================================
    // Tests
    // ======================================================================
    initial begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        periph.res_low <= 8'h3C;
        periph.res_high <= 8'h81;
        periph.ser_buf <= 8'hC3;
        foreach (rows[i]) begin
            if (rows[i].wr) op(lioreg_pkg::LIOREG_OP_WRITE, rows[i].a, 3'd0, rows[i].wd);
            op(lioreg_pkg::LIOREG_OP_TEST, rows[i].a, 3'd0, 8'h00);
            `CHK("table read", rows[i].ex, rd)
        end
        $display("test table done");
        op(lioreg_pkg::LIOREG_OP_WRITE, 6'h13, 3'd0, 8'h5A);
        op(lioreg_pkg::LIOREG_OP_SET, 6'h13, 3'd0, 8'h00);
        op(lioreg_pkg::LIOREG_OP_CLEAR, 6'h13, 3'd6, 8'h00);
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h13, 3'd0, 8'h00);
        `CHK("scratch bits", 8'h1B, rd)
        `CHK("skip one", 2'b10, sk)
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h13, 3'd2, 8'h00);
        `CHK("skip zero", 2'b01, sk)
        op(lioreg_pkg::LIOREG_OP_CLEAR, 6'h00, 3'd1, 8'h00);
        `CHK("power bits", 8'h0D, pwr)
        op(lioreg_pkg::LIOREG_OP_SET, 6'h00, 3'd1, 8'h00);
        op(lioreg_pkg::LIOREG_OP_CLEAR, 6'h17, 3'd3, 8'h00);
        `CHK("direction bits", 8'h07, dir)
        $display("test bits done");
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h20, 3'd0, 8'h00);
        `CHK("skip high", 2'b00, sk)
        op(lioreg_pkg::LIOREG_OP_CLEAR, 6'h33, 3'd0, 8'h00);
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h13, 3'd0, 8'h00);
        `CHK("no alias", 8'h1B, rd)
        $display("test range done");
        @(posedge core_clk) periph.t1_flags <= 8'h27;
        @(posedge core_clk) periph.t1_flags <= 8'h00;
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h0B, 3'd0, 8'h00);
        `CHK("flags raised", 8'h27, rd)
        op(lioreg_pkg::LIOREG_OP_SET, 6'h0B, 3'd0, 8'h00);
        op(lioreg_pkg::LIOREG_OP_CLEAR, 6'h0B, 3'd1, 8'h00);
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h0B, 3'd0, 8'h00);
        `CHK("flags bit ops", 8'h26, rd)
        op(lioreg_pkg::LIOREG_OP_WRITE, 6'h0B, 3'd0, 8'h04);
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h0B, 3'd0, 8'h00);
        `CHK("flags byte clear", 8'h22, rd)
        @(posedge core_clk) periph.cmp_out <= 1'b1;
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h08, 3'd0, 8'h00);
        `CHK("comparator out", 8'hEF, rd)
        @(posedge core_clk) periph.cnv_flags <= 8'h10;
        @(posedge core_clk) periph.cnv_flags <= 8'h00;
        op(lioreg_pkg::LIOREG_OP_CLEAR, 6'h06, 3'd0, 8'h00);
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h06, 3'd0, 8'h00);
        `CHK("converter flag kept", 8'hFE, rd)
        op(lioreg_pkg::LIOREG_OP_SET, 6'h06, 3'd4, 8'h00);
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h06, 3'd0, 8'h00);
        `CHK("converter flag cleared", 8'hEE, rd)
        op(lioreg_pkg::LIOREG_OP_WRITE, 6'h16, 3'd0, 8'h05);
        `CHK("pin toggle", 4'h5, tog)
        $display("test flags done");
        @(posedge core_clk) nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        `CHK("reset power", 8'h00, pwr)
        `CHK("reset direction", 8'h00, dir)
        op(lioreg_pkg::LIOREG_OP_TEST, 6'h13, 3'd0, 8'h00);
        `CHK("reset scratch", 8'h00, rd)
        $display("test reset done");
        final_report();
    end
endmodule
`default_nettype wire
